// ---- verilog/cae_exec.sv ----
// compact add execute datapath: immediate add and three-register add
module cae_exec
  import cae_pkg::*;
(
  input  wire logic               CLOCK_I,
  input  wire logic               RSTN_I,
  input  wire logic               IMM_VALID_I,
  input  wire logic [REG_W-1:0]   IMM_REG_I,
  input  wire logic [IMM_W-1:0]   IMM_VALUE_I,
  input  wire logic               RRR_VALID_I,
  input  wire logic [CODE_W-1:0]  FIRST_SRC_FIELD_I,
  input  wire logic [CODE_W-1:0]  SECOND_SRC_FIELD_I,
  input  wire logic [CODE_W-1:0]  DEST_FIELD_I,
  input  wire logic [DATA_W-1:0]  RD_A_DATA_I,
  input  wire logic [DATA_W-1:0]  RD_B_DATA_I,
  output logic                    BUSY_O,
  output logic                    DONE_O,
  output logic                    HALFWORD_ADV_O,
  output logic [REG_W-1:0]        RD_A_ADDR_O,
  output logic [REG_W-1:0]        RD_B_ADDR_O,
  output logic                    RD_EN_O,
  output logic                    WR_EN_O,
  output logic [REG_W-1:0]        WR_ADDR_O,
  output logic [DATA_W-1:0]       WR_DATA_O,
  output logic                    EXC_O
);

  // ----------------------------------------------------------------
  // register code mapping
  // ----------------------------------------------------------------
  logic [REG_W-1:0] src_a_map;
  logic [REG_W-1:0] src_b_map;
  logic [REG_W-1:0] dst_map;

  cae_reg_map u_map_a (.code_i(FIRST_SRC_FIELD_I),  .reg_o(src_a_map));
  cae_reg_map u_map_b (.code_i(SECOND_SRC_FIELD_I), .reg_o(src_b_map));
  cae_reg_map u_map_d (.code_i(DEST_FIELD_I),       .reg_o(dst_map));

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  cae_state_t       state_reg;
  cae_state_t       state_next;
  cae_op_t          op_reg;
  logic [REG_W-1:0] dst_reg;
  logic [DATA_W-1:0] imm_ext_reg;
  logic             accept;

  // new work is taken only in idle; immediate add has priority
  assign accept = (state_reg == CAE_IDLE) && (IMM_VALID_I || RRR_VALID_I);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CAE_IDLE:  if (accept) state_next = CAE_READ;
      CAE_READ:  state_next = CAE_WRITE;
      CAE_WRITE: state_next = CAE_IDLE;
      default:   state_next = CAE_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      state_reg <= CAE_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // operand capture and register reads
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      op_reg      <= CAE_OP_NONE;
      dst_reg     <= REG_ZERO;
      imm_ext_reg <= DATA_ZERO;
      RD_A_ADDR_O <= REG_ZERO;
      RD_B_ADDR_O <= REG_ZERO;
      RD_EN_O     <= 1'b0;
    end
    else
    begin
      RD_EN_O <= accept;
      if (accept && IMM_VALID_I)
      begin
        op_reg      <= CAE_OP_IMM;
        dst_reg     <= IMM_REG_I;
        RD_A_ADDR_O <= IMM_REG_I;
        RD_B_ADDR_O <= REG_ZERO;
        imm_ext_reg <= {{(DATA_W-IMM_W){IMM_VALUE_I[IMM_W-1]}},
                        IMM_VALUE_I};
      end
      else if (accept)
      begin
        op_reg      <= CAE_OP_RRR;
        dst_reg     <= dst_map;
        RD_A_ADDR_O <= src_a_map;
        RD_B_ADDR_O <= src_b_map;
        imm_ext_reg <= DATA_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // add and write-back
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] addend;
  logic [DATA_W-1:0] sum;

  assign addend = (op_reg == CAE_OP_IMM) ? imm_ext_reg : RD_B_DATA_I;
  // carry out is dropped on purpose: plain modulo arithmetic
  assign sum = DATA_W'(RD_A_DATA_I + addend);

  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      WR_EN_O        <= 1'b0;
      WR_ADDR_O      <= REG_ZERO;
      WR_DATA_O      <= DATA_ZERO;
      DONE_O         <= 1'b0;
      HALFWORD_ADV_O <= 1'b0;
    end
    else
    begin
      WR_EN_O        <= (state_reg == CAE_READ);
      DONE_O         <= (state_reg == CAE_READ);
      // one halfword consumed per completed instruction
      HALFWORD_ADV_O <= (state_reg == CAE_READ);
      if (state_reg == CAE_READ)
      begin
        WR_ADDR_O <= dst_reg;
        WR_DATA_O <= sum;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      BUSY_O <= 1'b0;
      EXC_O  <= 1'b0;
    end
    else
    begin
      BUSY_O <= (state_next != CAE_IDLE);
      EXC_O  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_imm_take;
    accept && IMM_VALID_I;
  endsequence

  sequence s_rrr_take;
    accept && !IMM_VALID_I;
  endsequence

  property p_imm_result;
    logic [REG_W-1:0] r;
    logic [DATA_W-1:0] e;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (s_imm_take, r = IMM_REG_I,
       e = {{(DATA_W-IMM_W){IMM_VALUE_I[IMM_W-1]}}, IMM_VALUE_I})
      |-> ##1 (RD_A_ADDR_O == r) ##1
          (WR_EN_O && WR_ADDR_O == r
           && WR_DATA_O == DATA_W'($past(RD_A_DATA_I) + e));
  endproperty
  a_imm_result: assert property (p_imm_result)
    else $error("immediate add result or target wrong");

  property p_imm_sel;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      s_imm_take |=> (RD_A_ADDR_O == $past(IMM_REG_I) && RD_EN_O);
  endproperty
  a_imm_sel: assert property (p_imm_sel)
    else $error("immediate add register select wrong");

  property p_imm_neg;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (s_imm_take and IMM_VALUE_I[IMM_W-1])
      |=> (imm_ext_reg[DATA_W-1:IMM_W] == '1);
  endproperty
  a_imm_neg: assert property (p_imm_neg)
    else $error("negative immediate not sign extended");

  property p_no_exc;
    @(posedge CLOCK_I) disable iff (!RSTN_I) !EXC_O;
  endproperty
  a_no_exc: assert property (p_no_exc)
    else $error("exception raised by add");

  property p_rrr_result;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      s_rrr_take ##1 1'b1 |=>
        (WR_EN_O && WR_DATA_O
         == DATA_W'($past(RD_A_DATA_I) + $past(RD_B_DATA_I)));
  endproperty
  a_rrr_result: assert property (p_rrr_result)
    else $error("three register add sum wrong");

  property p_rrr_regs;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      s_rrr_take |=> ##1
        ((WR_ADDR_O inside {5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
                            5'h07, 5'h10, 5'h11}) && WR_EN_O);
  endproperty
  a_rrr_regs: assert property (p_rrr_regs)
    else $error("three register add reached illegal register");

  property p_one_halfword;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      accept |-> ##2 HALFWORD_ADV_O ##1 !HALFWORD_ADV_O;
  endproperty
  a_one_halfword: assert property (p_one_halfword)
    else $error("halfword advance not a single pulse");

  property p_code_map;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (s_rrr_take and FIRST_SRC_FIELD_I < CODE_HI_LIMIT)
      |=> RD_A_ADDR_O == (HI_REG_BASE | {2'h0, $past(FIRST_SRC_FIELD_I)});
  endproperty
  a_code_map: assert property (p_code_map)
    else $error("low register code not mapped upward");

endmodule // cae_exec

// ---- verilog/cae_pkg.sv ----
// constants and types for the compact add execute datapath
package cae_pkg;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IMM_W    = 4;
  localparam int unsigned REG_W    = 5;
  localparam int unsigned CODE_W   = 3;
  localparam int unsigned INSTR_W  = 16;
  localparam logic [REG_W-1:0] HI_REG_BASE = 5'h10;
  localparam logic [CODE_W-1:0] CODE_HI_LIMIT = 3'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [REG_W-1:0]  REG_ZERO  = 5'h00;

  typedef enum logic [2:0] {
    CAE_IDLE  = 3'b001,
    CAE_READ  = 3'b010,
    CAE_WRITE = 3'b100
  } cae_state_t;

  typedef enum logic [1:0] {
    CAE_OP_NONE = 2'h0,
    CAE_OP_IMM  = 2'h1,
    CAE_OP_RRR  = 2'h2
  } cae_op_t;
endpackage : cae_pkg

// ---- verilog/cae_reg_map.sv ----
// maps a 3-bit compact register code onto a register number
module cae_reg_map
  import cae_pkg::*;
(
  input  wire logic [CODE_W-1:0] code_i,
  output logic      [REG_W-1:0]  reg_o
);
  // codes 0 and 1 reach the two upper registers, the rest map straight
  always_comb
  begin
    if (code_i < CODE_HI_LIMIT)
      reg_o = HI_REG_BASE | {2'h0, code_i};
    else
      reg_o = {2'h0, code_i};
  end
endmodule // cae_reg_map

// ---- test/cae_gpr_model.sv ----
// register file model on the far side of the compact add datapath
// ----------------------------------------------------------------
// register array with combinational read
// ----------------------------------------------------------------
module cae_gpr_model
  import cae_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rd_en_i,
  input  wire logic [REG_W-1:0]  rd_a_addr_i,
  input  wire logic [REG_W-1:0]  rd_b_addr_i,
  input  wire logic              wr_en_i,
  input  wire logic [REG_W-1:0]  wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic      [DATA_W-1:0] rd_a_data_o,
  output logic      [DATA_W-1:0] rd_b_data_o
);
  logic [DATA_W-1:0] mem [32];

  // outside the read cycle the lines carry inverted data, so a late
  // sample can never pass for the right operand
  assign rd_a_data_o = rd_en_i ? mem[rd_a_addr_i] : ~mem[rd_a_addr_i];
  assign rd_b_data_o = rd_en_i ? mem[rd_b_addr_i] : ~mem[rd_b_addr_i];

  always @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule // cae_gpr_model

// ---- test/cae_exec_test.sv ----
// self-checking bench for the compact add datapath
module cae_exec_test
  import cae_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, iv, rv, busy, done, adv, rden, wen, exc;
  logic [REG_W-1:0]  ireg, raa, rab, wa;
  logic [IMM_W-1:0]  ival;
  logic [CODE_W-1:0] f1, f2, fd;
  logic [DATA_W-1:0] rda, rdb, wd;
  logic [DATA_W-1:0] shadow [32];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  cae_exec i_cae_exec (.CLOCK_I(clk), .RSTN_I(rstn), .IMM_VALID_I(iv),
    .IMM_REG_I(ireg), .IMM_VALUE_I(ival), .RRR_VALID_I(rv),
    .FIRST_SRC_FIELD_I(f1), .SECOND_SRC_FIELD_I(f2), .DEST_FIELD_I(fd),
    .RD_A_DATA_I(rda), .RD_B_DATA_I(rdb), .BUSY_O(busy), .DONE_O(done),
    .HALFWORD_ADV_O(adv), .RD_A_ADDR_O(raa), .RD_B_ADDR_O(rab),
    .RD_EN_O(rden), .WR_EN_O(wen), .WR_ADDR_O(wa), .WR_DATA_O(wd),
    .EXC_O(exc));

  cae_gpr_model i_cae_gpr_model (.clock_i(clk), .rd_en_i(rden),
    .rd_a_addr_i(raa), .rd_b_addr_i(rab), .wr_en_i(wen),
    .wr_addr_i(wa), .wr_data_i(wd), .rd_a_data_o(rda),
    .rd_b_data_o(rdb));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [REG_W-1:0] map(input logic [CODE_W-1:0] c);
    return (c < 3'h2) ? 5'h10 + {2'h0, c} : {2'h0, c};
  endfunction

  // request already driven; valid is dropped after the taking edge
  task automatic finish_op(input logic [REG_W-1:0] ra, rb, a,
                           input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk);
    iv = 1'b0;
    rv = 1'b0;
    check(rden, 1'b1);
    check(busy, 1'b1);
    check(raa, ra);
    check(rab, rb);
    while (done !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    check(n, 1);
    check(wen, 1'b1);
    check(adv, 1'b1);
    check(wa, a);
    check(wd, d);
    check(exc, 1'b0);
    shadow[a] = d;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_imm(input logic [REG_W-1:0] r);
    logic [DATA_W-1:0] sx;
    for (int c = 0; c < 16; c++)
    begin
      sx = {{28{c[3]}}, c[3:0]};
      @(negedge clk);
      iv = 1'b1;
      ireg = r;
      ival = c[3:0];
      finish_op(r, REG_ZERO, r, shadow[r] + sx);
    end
  endtask

  task automatic test_rrr();
    for (int c = 0; c < 8; c++)
    begin
      @(negedge clk);
      rv = 1'b1;
      f1 = c[2:0];
      f2 = 3'h7 - c[2:0];
      fd = c[2:0] + 3'h3;
      finish_op(map(f1), map(f2), map(fd),
                shadow[map(f1)] + shadow[map(f2)]);
    end
  endtask

  // both requests at once: the immediate add goes first
  task automatic test_prio();
    @(negedge clk);
    iv = 1'b1;
    rv = 1'b1;
    ireg = 5'h04;
    ival = 4'h8;
    finish_op(5'h04, REG_ZERO, 5'h04, shadow[4] + 32'hffff_fff8);
    // the losing request was withdrawn, so no second write may follow
    @(negedge clk);
    check(wen, 1'b0);
    check(busy, 1'b0);
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    {rstn, iv, rv, ireg, ival, f1, f2, fd} = '0;
    for (int i = 0; i < 32; i++)
    begin
      shadow[i] = 32'h8000_0000 + i * 32'h0111_1111;
      i_cae_gpr_model.mem[i] = shadow[i];
    end
    shadow[31] = 32'h0000_0004;
    i_cae_gpr_model.mem[31] = shadow[31];
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    check(busy, 1'b0);
    test_imm(5'h1f);
    test_imm(5'h11);
    test_rrr();
    test_prio();
    complete_run();
  end
endmodule // cae_exec_test
